//--- verilog/tsw_pkg.sv
`default_nettype none
package tsw_pkg;
    localparam int NUM_STREAMS = 4;
    localparam int NUM_CHANNELS = 128;
    localparam int CM_DEPTH = 512;
    localparam int NUM_BANKS = 3;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int FRAME_NS = 125000;
    localparam int FRAME_CYCLES = FRAME_NS * 1000 / CLK_PERIOD_PS;
    localparam int SLOT_CYCLES = FRAME_CYCLES / NUM_CHANNELS;
    // Half period of the 16.384 MHz master clock
    localparam int MCLK_HALF_PS = 30518;
    localparam logic [3:0] OFS_MAX_STEPS = 4'h9;
    localparam logic [13:0] FRAME_HALF = 14'(FRAME_CYCLES / 2);
    localparam logic [6:0] SLOT_LAST = 7'(SLOT_CYCLES - 1);
    localparam int BP_WAIT_MAX = 520;

    localparam logic [6:0] REG_CONTROL = 7'h00;
    localparam logic [6:0] REG_IFACE_MODE = 7'h01;
    localparam logic [6:0] REG_ALIGN = 7'h02;
    localparam logic [6:0] REG_OFFSET = 7'h03;

    localparam int CR_STREAM_LSB = 0;
    localparam int CR_MEM_SEL = 4;
    localparam int CR_BLOCK_MODE = 5;
    localparam logic [15:0] CR_WMASK = 16'h0033;
    localparam logic [15:0] CR_RESET = 16'h0000;

    localparam int IMS_START_EVAL = 2;
    localparam int IMS_STANDBY = 3;
    localparam int IMS_BLOCK_GO = 4;
    localparam int IMS_PATTERN_LSB = 5;
    localparam logic [15:0] IMS_WMASK = 16'h03FC;
    localparam logic [15:0] IMS_RESET = 16'h0000;

    localparam int ALIGN_DONE_BIT = 12;
    localparam logic [11:0] ALIGN_SAT = 12'hFFF;
    localparam logic [11:0] ALIGN_RESET = 12'h000;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;

    localparam int CM_CHAN_LSB = 0;
    localparam int CM_STREAM_LSB = 7;
    localparam int CM_PATTERN_LSB = 11;
    localparam int CM_LOOPBACK = 11;
    localparam int CM_CONST_DELAY = 12;
    localparam int CM_PROC_CHAN = 13;
    localparam int CM_OUT_EN = 14;

    typedef struct packed {
        logic [6:0] chan;
        logic [3:0] drive;
        logic [31:0] bytes;
    } tsw_tx_word_type;

    typedef enum logic [1:0] {
        BP_IDLE = 2'b01,
        BP_RUN = 2'b10
    } tsw_bp_state_type;

    typedef enum logic [3:0] {
        EV_IDLE = 4'b0001,
        EV_ARM = 4'b0010,
        EV_MEAS = 4'b0100,
        EV_DONE = 4'b1000
    } tsw_ev_state_type;

    // Offset steps to clock cycles, rounded down
    function automatic logic [6:0] ofs_cycles(input logic [3:0] steps);
        logic [3:0] s;
        s = (steps > OFS_MAX_STEPS) ? OFS_MAX_STEPS : steps;
        ofs_cycles = 7'((int'(s) * MCLK_HALF_PS) / CLK_PERIOD_PS);
    endfunction

    // Bank index d frames back, modulo three
    function automatic logic [1:0] bank_back(input logic [1:0] b, input logic [1:0] d);
        logic [2:0] t;
        t = {1'b0, b} + 3'h3 - {1'b0, d};
        bank_back = (t >= 3'h3) ? 2'(t - 3'h3) : t[1:0];
    endfunction
endpackage
`default_nettype wire

//--- verilog/tsw_pair_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module tsw_pair_buffer
    import tsw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire tsw_tx_word_type in_word,
    output logic out_valid,
    input wire logic out_ready,
    output tsw_tx_word_type out_word
);
    tsw_tx_word_type entry_r [2];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_word = entry_r[rd_ptr_r];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            entry_r[0] <= '0;
            entry_r[1] <= '0;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                entry_r[wr_ptr_r] <= in_word;
                wr_ptr_r <= !wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= !rd_ptr_r;
            end
            count_r <= 2'(count_r + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule // tsw_pair_buffer
`default_nettype wire

//--- verilog/tsw_switch.sv
`timescale 1ns/1ps
`default_nettype none
module tsw_switch
    import tsw_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic CS_B,
    input wire logic ADDRESS_STROBE,
    input wire logic DATA_STROBE_READ,
    input wire logic RW_WR,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] DATA_I,
    output logic [15:0] DATA_O,
    output logic DATA_OE_B,
    output logic TRANSFER_ACK_N,
    output logic TRANSFER_ACK_OE_B,
    input wire logic INTERFACE_MODE_PIN,
    input wire logic WIDE_FRAME_SELECT_PIN,
    input wire logic OUTPUT_DRIVE_PIN,
    input wire logic FRAME_PULSE_IN,
    input wire logic EVAL_OR_HALF_CLOCK_PIN,
    input wire logic [31:0] RX_BYTES,
    output logic TX_VALID,
    input wire logic TX_READY,
    output tsw_tx_word_type TX_WORD
);
    // Pin synchronisers
    logic [64:0] sy1_r;
    logic [64:0] sy2_r;
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sy1_r <= '0;
            sy2_r <= '0;
        end else begin
            sy1_r <= {FRAME_PULSE_IN, EVAL_OR_HALF_CLOCK_PIN, WIDE_FRAME_SELECT_PIN,
                      OUTPUT_DRIVE_PIN, INTERFACE_MODE_PIN, CS_B, ADDRESS_STROBE,
                      DATA_STROBE_READ, RW_WR, ADDR, DATA_I, RX_BYTES};
            sy2_r <= sy1_r;
        end
    end
    wire pulse_s = sy2_r[64];
    wire eval_s = sy2_r[63];
    wire wide_s = sy2_r[62];
    wire drive_pin_s = sy2_r[61];
    wire imode_s = sy2_r[60];
    wire cs_b_s = sy2_r[59];
    wire astb_s = sy2_r[58];
    wire dstb_s = sy2_r[57];
    wire rw_s = sy2_r[56];
    wire [7:0] addr_s = sy2_r[55:48];
    wire [15:0] din_s = sy2_r[47:32];
    wire [31:0] rx_s = sy2_r[31:0];

    // Frame timebase
    logic pulse_d_r;
    logic eval_d_r;
    logic fmt_fall_r;
    logic [13:0] gap_r;
    logic [6:0] cyc_r;
    logic [6:0] slot_r;
    logic [1:0] bank_r;
    wire pulse_edge = pulse_s ^ pulse_d_r;
    wire frame_evt = pulse_edge && (gap_r > FRAME_HALF);
    wire slot_end = (cyc_r == SLOT_LAST);
    wire fetch_now = (cyc_r == 7'h00);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pulse_d_r <= 1'b0;
            eval_d_r <= 1'b0;
            gap_r <= 14'h0000;
            fmt_fall_r <= 1'b1;
        end else begin
            pulse_d_r <= pulse_s;
            eval_d_r <= eval_s;
            gap_r <= pulse_edge ? 14'h0000 : ((&gap_r) ? gap_r : 14'(gap_r + 14'h0001));
            if (frame_evt) begin
                fmt_fall_r <= !pulse_s;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cyc_r <= 7'h00;
            slot_r <= 7'h00;
            bank_r <= 2'h0;
        end else if (frame_evt) begin
            cyc_r <= 7'h00;
            slot_r <= 7'h00;
            bank_r <= bank_back(bank_r, 2'h2);
        end else begin
            cyc_r <= slot_end ? 7'h00 : 7'(cyc_r + 7'h01);
            slot_r <= slot_end ? 7'(slot_r + 7'h01) : slot_r;
        end
    end

    // Registers and memories
    logic [15:0] control_reg_r;
    logic [15:0] interface_mode_reg_r;
    logic [15:0] input_offset_reg_r;
    logic [11:0] align_val_r;
    logic eval_done_flag_r;
    logic [15:0] cmem_r [CM_DEPTH];
    logic [7:0] dmem_r [NUM_BANKS][CM_DEPTH];

    // Processor port
    logic mode2_r;
    logic astb_d_r;
    logic acc_d_r;
    logic ack_r;
    logic ack_hi_r;
    logic rd_lat_r;
    logic [7:0] alat_r;
    logic [15:0] dout_r;
    wire mux2 = imode_s && mode2_r;
    wire strobe_w = mux2 ? (!dstb_s || !rw_s) : dstb_s;
    wire rd_w = mux2 ? !dstb_s : rw_s;
    wire acc_w = !cs_b_s && strobe_w;
    wire acc_start = acc_w && !acc_d_r;
    wire [7:0] addr_w = imode_s ? alat_r : addr_s;
    wire is_mem = addr_w[7];
    wire [8:0] mem_idx = {control_reg_r[CR_STREAM_LSB +: 2], addr_w[6:0]};
    wire host_wr = acc_start && !rd_w;
    wire reg_wr = host_wr && !is_mem;
    wire cm_host_wr = host_wr && is_mem && !control_reg_r[CR_MEM_SEL];
    wire [15:0] align_word = 16'(align_val_r) | (16'(eval_done_flag_r) << ALIGN_DONE_BIT);
    wire [15:0] reg_rd = (addr_w[6:0] == REG_CONTROL) ? control_reg_r :
                         (addr_w[6:0] == REG_IFACE_MODE) ? interface_mode_reg_r :
                         (addr_w[6:0] == REG_ALIGN) ? align_word :
                         (addr_w[6:0] == REG_OFFSET) ? input_offset_reg_r : 16'h0000;
    wire [15:0] mem_rd = control_reg_r[CR_MEM_SEL] ? {8'h00, dmem_r[bank_r][mem_idx]} :
                         cmem_r[mem_idx];

    assign DATA_O = dout_r;
    assign DATA_OE_B = !(ack_r && rd_lat_r);
    assign TRANSFER_ACK_N = !ack_r;
    assign TRANSFER_ACK_OE_B = !(ack_r || ack_hi_r);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode2_r <= 1'b0;
            astb_d_r <= 1'b0;
            alat_r <= 8'h00;
        end else begin
            astb_d_r <= astb_s;
            if (imode_s && astb_s && !astb_d_r) begin
                mode2_r <= dstb_s;
            end
            if (imode_s && !astb_s && astb_d_r) begin
                alat_r <= din_s[7:0];
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            acc_d_r <= 1'b0;
            ack_r <= 1'b0;
            ack_hi_r <= 1'b0;
            rd_lat_r <= 1'b0;
            dout_r <= 16'h0000;
        end else begin
            acc_d_r <= acc_w;
            ack_r <= acc_start || (ack_r && acc_w);
            ack_hi_r <= ack_r && !acc_w;
            if (acc_start) begin
                rd_lat_r <= rd_w;
                dout_r <= is_mem ? mem_rd : reg_rd;
            end
        end
    end

    // Block programming
    tsw_bp_state_type bp_state_r;
    logic [8:0] bp_idx_r;
    wire bp_start = (bp_state_r == BP_IDLE) && control_reg_r[CR_BLOCK_MODE] &&
                    interface_mode_reg_r[IMS_BLOCK_GO];
    wire bp_done = (bp_state_r == BP_RUN) && (&bp_idx_r);
    wire [15:0] bp_word = 16'(16'(interface_mode_reg_r[IMS_PATTERN_LSB +: 5]) << CM_PATTERN_LSB);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bp_state_r <= BP_IDLE;
            bp_idx_r <= 9'h000;
        end else begin
            case (bp_state_r)
                BP_IDLE: begin
                    bp_idx_r <= 9'h000;
                    if (bp_start) begin
                        bp_state_r <= BP_RUN;
                    end
                end
                BP_RUN: begin
                    bp_idx_r <= 9'(bp_idx_r + 9'h001);
                    if (bp_done) begin
                        bp_state_r <= BP_IDLE;
                    end
                end
                default: bp_state_r <= BP_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (bp_state_r == BP_RUN) begin
            cmem_r[bp_idx_r] <= bp_word;
        end else if (cm_host_wr) begin
            cmem_r[mem_idx] <= din_s;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            control_reg_r <= CR_RESET;
            interface_mode_reg_r <= IMS_RESET;
            input_offset_reg_r <= OFFSET_RESET;
        end else begin
            if (reg_wr && addr_w[6:0] == REG_CONTROL) begin
                control_reg_r <= din_s & CR_WMASK;
            end
            if (reg_wr && addr_w[6:0] == REG_OFFSET) begin
                input_offset_reg_r <= din_s;
            end
            if (reg_wr && addr_w[6:0] == REG_IFACE_MODE) begin
                interface_mode_reg_r <= din_s & IMS_WMASK;
            end else if (bp_done) begin
                interface_mode_reg_r[IMS_BLOCK_GO] <= 1'b0;
            end
        end
    end

    // Alignment evaluation
    tsw_ev_state_type ev_r;
    logic start_d_r;
    logic got_r;
    logic [11:0] meas_r;
    wire start_eval = interface_mode_reg_r[IMS_START_EVAL];
    wire eval_match = fmt_fall_r ? (eval_d_r && !eval_s) : (!eval_d_r && eval_s);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ev_r <= EV_IDLE;
            start_d_r <= 1'b0;
        end else begin
            start_d_r <= start_eval;
            if (!start_eval || wide_s) begin
                ev_r <= EV_IDLE;
            end else begin
                case (ev_r)
                    EV_IDLE: ev_r <= start_d_r ? EV_IDLE : EV_ARM;
                    EV_ARM: ev_r <= frame_evt ? EV_MEAS : EV_ARM;
                    EV_MEAS: ev_r <= frame_evt ? EV_DONE : EV_MEAS;
                    EV_DONE: ev_r <= EV_DONE;
                    default: ev_r <= EV_IDLE;
                endcase
            end
        end
    end

    // Result and flag after second frame
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            got_r <= 1'b0;
            meas_r <= ALIGN_RESET;
            align_val_r <= ALIGN_RESET;
            eval_done_flag_r <= 1'b0;
        end else begin
            if (ev_r == EV_ARM) begin
                got_r <= 1'b0;
                meas_r <= ALIGN_RESET;
            end else if (ev_r == EV_MEAS && !got_r) begin
                got_r <= eval_match;
                meas_r <= (eval_match || meas_r == ALIGN_SAT) ? meas_r : 12'(meas_r + 12'h001);
            end
            if (ev_r == EV_MEAS && frame_evt && start_eval && !wide_s) begin
                align_val_r <= meas_r;
                eval_done_flag_r <= 1'b1;
            end else if (!start_eval || wide_s) begin
                eval_done_flag_r <= 1'b0;
            end
        end
    end

    // Serial data path
    tsw_tx_word_type fetch_r;
    tsw_tx_word_type tx_cur_r;
    logic fetch_vld_r;
    logic buf_in_ready;
    logic [3:0] cap_w;
    logic [7:0] wbyte_w [NUM_STREAMS];
    logic [31:0] fbytes_w;
    logic [3:0] fdrive_w;
    wire [6:0] fch = 7'(slot_r + 7'h01);
    wire [1:0] fbank = (fch == 7'h00) ? bank_back(bank_r, 2'h2) : bank_r;
    wire drive_all = drive_pin_s || interface_mode_reg_r[IMS_STANDBY];

    for (genvar k = 0; k < NUM_STREAMS; k++) begin : g_stream
        wire [15:0] cm_out = cmem_r[{2'(k), fch}];
        wire [15:0] cm_in = cmem_r[{2'(k), slot_r}];
        wire [6:0] src_ch = cm_out[CM_CHAN_LSB +: 7];
        wire late_src = ({1'b0, fch} >= ({1'b0, src_ch} + 8'h03));
        // Source at least three slots back, same frame
        wire [1:0] src_bank = cm_out[CM_CONST_DELAY] ? bank_back(fbank, 2'h2) :
                              (late_src ? fbank : bank_back(fbank, 2'h1));
        assign cap_w[k] = (cyc_r == ofs_cycles(input_offset_reg_r[4 * k +: 4]));
        // Loopback replaces received byte
        // Current slot's word is still in the fetch register at slot start
        assign wbyte_w[k] = !cm_in[CM_LOOPBACK] ? rx_s[8 * k +: 8] :
                            fetch_now ? fetch_r.bytes[8 * k +: 8] : tx_cur_r.bytes[8 * k +: 8];
        assign fbytes_w[8 * k +: 8] = cm_out[CM_PROC_CHAN] ? cm_out[7:0] :
                                      dmem_r[src_bank][{cm_out[CM_STREAM_LSB +: 2], src_ch}];
        assign fdrive_w[k] = cm_out[CM_OUT_EN] && drive_all;
    end

    always_ff @(posedge REF_CLK) begin
        for (int k = 0; k < NUM_STREAMS; k++) begin
            if (cap_w[k]) begin
                dmem_r[bank_r][{2'(k), slot_r}] <= wbyte_w[k];
            end
        end
    end

    // Fetch next channel at slot start
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            fetch_r <= '0;
            tx_cur_r <= '0;
            fetch_vld_r <= 1'b0;
        end else if (fetch_now) begin
            tx_cur_r <= fetch_r;
            fetch_r <= '{chan: fch, drive: fdrive_w, bytes: fbytes_w};
            fetch_vld_r <= 1'b1;
        end else if (buf_in_ready) begin
            fetch_vld_r <= 1'b0;
        end
    end

    tsw_pair_buffer u_tx_buffer (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .in_valid(fetch_vld_r),
        .in_ready(buf_in_ready),
        .in_word(fetch_r),
        .out_valid(TX_VALID),
        .out_ready(TX_READY),
        .out_word(TX_WORD)
    );

    a_bp_go_clears:
    assert property (@(posedge REF_CLK) disable iff (!RST_B)
        bp_start |-> ##[1:520] !interface_mode_reg_r[IMS_BLOCK_GO])
        else $error("block program go bit not cleared");
    a_bp_pattern_write:
    assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (bp_state_r == BP_RUN) |=> (cmem_r[$past(bp_idx_r)] == $past(bp_word)))
        else $error("block program word wrong");
    a_done_on_frame:
    assert property (@(posedge REF_CLK) disable iff (!RST_B)
        $rose(eval_done_flag_r) |-> $past(frame_evt) && $past(ev_r == EV_MEAS))
        else $error("done flag not on second frame");
    a_wide_no_eval:
    assert property (@(posedge REF_CLK) disable iff (!RST_B)
        wide_s |=> (ev_r == EV_IDLE) && !eval_done_flag_r)
        else $error("evaluation active in wide-frame mode");
    a_align_read_only:
    assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (reg_wr && addr_w[6:0] == REG_ALIGN && ev_r != EV_MEAS) |=> $stable(align_val_r))
        else $error("result register was written");
    a_ack_answer:
    assert property (@(posedge REF_CLK) disable iff (!RST_B)
        acc_start |=> !TRANSFER_ACK_N && !TRANSFER_ACK_OE_B)
        else $error("no acknowledge after access");
    a_drive_gating:
    assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (fetch_now && !drive_all) |=> (fetch_r.drive == 4'h0))
        else $error("driver enabled while all outputs off");
    a_fetch_ahead:
    assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (fetch_now && !frame_evt) |=> (fetch_r.chan == 7'(slot_r + 7'h01)))
        else $error("fetch not one slot ahead");
    a_mode2_latch:
    assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (imode_s && astb_s && !astb_d_r) |=> (mode2_r == $past(dstb_s)))
        else $error("multiplexed mode not latched");
endmodule // tsw_switch
`default_nettype wire

//--- tb/tsw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsw_host_model
    import tsw_pkg::*;
(
    input wire logic clk,
    output logic cs_b,
    output logic strobe,
    output logic astb,
    output logic rw,
    output logic [7:0] addr,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic data_oe_b,
    input wire logic ack_n,
    input wire logic ack_oe_b
);
    // Pull-up holds the ack line high while released
    wire logic ack_w = ack_oe_b ? 1'b1 : ack_n;
    initial begin
        cs_b = 1'b1;
        strobe = 1'b0;
        astb = 1'b0;
        rw = 1'b1;
        addr = 8'h00;
        wdata = 16'h0000;
    end
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cs_b <= 1'b0;
        strobe <= 1'b1;
        rw <= rd;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack_w !== 1'b0 && n < 50);
        // Data counts only while the device drives the bus on reads
        q = (n < 50 && data_oe_b === !rd) ? rdata : 16'hxxxx;
        cs_b <= 1'b1;
        strobe <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        n = 0;
        while (ack_oe_b !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
    endtask
    // address phase, read strobe low picks mode 1
    task automatic latch(input logic [7:0] a);
        @(posedge clk);
        astb <= 1'b1;
        wdata <= {8'h00, a};
        repeat (3) @(posedge clk);
        astb <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule // tsw_host_model
`default_nettype wire

//--- tb/test_tsw_switch.sv
`timescale 1ns/1ps
`default_nettype none
module test_tsw_switch
    import tsw_pkg::*;
;
    logic clk, cs_b, stb, rw, ack_n, ack_oe_b, tx_valid, astb, data_oe_b;
    logic rst_b = 1'b0, fp = 1'b1, ev = 1'b1, wfs = 1'b0, output_drive_pin = 1'b0, tx_ready = 1'b1;
    logic im = 1'b0;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, last_q;
    logic [13:0] fcnt = 14'h0000;
    tsw_tx_word_type tx_word, w;
    int failures, comparisons;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // low-going frame pulse, eval edge 20 cycles behind
    always @(posedge clk) begin
        fcnt <= (fcnt == 14'(FRAME_CYCLES - 1)) ? 14'h0000 : fcnt + 14'h0001;
        fp <= !(fcnt < 14'h0008);
        ev <= !(fcnt >= 14'h0014 && fcnt < 14'h0028);
    end
    tsw_switch DUT (.REF_CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .ADDRESS_STROBE(astb),
        .DATA_STROBE_READ(stb), .RW_WR(rw), .ADDR(addr), .DATA_I(wdata), .DATA_O(rdata),
        .DATA_OE_B(data_oe_b), .TRANSFER_ACK_N(ack_n), .TRANSFER_ACK_OE_B(ack_oe_b),
        .INTERFACE_MODE_PIN(im), .WIDE_FRAME_SELECT_PIN(wfs), .OUTPUT_DRIVE_PIN(output_drive_pin),
        .FRAME_PULSE_IN(fp), .EVAL_OR_HALF_CLOCK_PIN(ev), .RX_BYTES(32'h4433_2211),
        .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_WORD(tx_word));
    tsw_host_model HOST (.clk(clk), .cs_b(cs_b), .strobe(stb), .astb(astb), .rw(rw),
        .addr(addr), .wdata(wdata), .rdata(rdata), .data_oe_b(data_oe_b), .ack_n(ack_n),
        .ack_oe_b(ack_oe_b));
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        HOST.xfer(1'b0, a, d, q);
        check("write ack", 16'h0001, 16'(q !== 16'hxxxx));
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e,
        input string nm);
        HOST.xfer(1'b1, a, 16'h0000, last_q);
        check(nm, e, last_q & m);
    endtask
    task automatic tx_get(input logic [6:0] ch);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(tx_valid === 1'b1 && tx_ready && tx_word.chan === ch) && n < 20000);
        w = tx_word;
        check("tx chan", 16'(ch), 16'(w.chan));
        @(posedge clk);
    endtask
    task automatic t_regs();
        rd(8'h00, 16'hFFFF, 16'h0000, "control");
        rd(8'h01, 16'hFFFF, 16'h0000, "iface");
        rd(8'h02, 16'hFFFF, 16'h0000, "align");
        rd(8'h03, 16'hFFFF, 16'h0000, "offset");
        rd(8'h05, 16'hFFFF, 16'h0000, "unmapped");
        wr(8'h00, 16'hFFFF);
        rd(8'h00, 16'hFFFF, 16'h0033, "control rw");
        wr(8'h02, 16'hFFFF);
        rd(8'h02, 16'hFFFF, 16'h0000, "align ro");
        wr(8'h01, 16'h0008);
        rd(8'h01, 16'hFFFF, 16'h0008, "iface rw");
    endtask
    task automatic t_block();
        wr(8'h00, 16'h0020);
        wr(8'h01, 16'h02D0);
        repeat (BP_WAIT_MAX) @(posedge clk);
        rd(8'h01, 16'hFFFF, 16'h02C0, "go cleared");
        wr(8'h00, 16'h0002);
        rd(8'h87, 16'hFFFF, 16'hB000, "pattern");
        wr(8'h00, 16'h0000);
        wr(8'h85, 16'h60A5);
        rd(8'h85, 16'hFFFF, 16'h60A5, "conn rw");
    endtask
    task automatic t_eval();
        // start bit held low a frame
        repeat (FRAME_CYCLES) @(posedge clk);
        wr(8'h01, 16'h0004);
        repeat (FRAME_CYCLES / 2) @(posedge clk);
        rd(8'h02, 16'h1000, 16'h0000, "done early");
        repeat (3 * FRAME_CYCLES / 2 + SLOT_CYCLES) @(posedge clk);
        rd(8'h02, 16'h1000, 16'h1000, "done");
        check("falling offset", 16'h0001, 16'(last_q[11:0] >= 19 && last_q[11:0] <= 21));
        @(posedge clk) wfs <= 1'b1;
        repeat (10) @(posedge clk);
        rd(8'h02, 16'h1000, 16'h0000, "wide off");
        @(posedge clk) wfs <= 1'b0;
        wr(8'h01, 16'h0000);
    endtask
    task automatic t_dmem();
        wr(8'h00, 16'h0011);
        rd(8'h83, 16'hFFFF, 16'h0022, "data mem");
        wr(8'h83, 16'h00FF);
        rd(8'h83, 16'hFFFF, 16'h0022, "data ro");
        wr(8'h00, 16'h0000);
    endtask
    task automatic t_mux();
        @(posedge clk) im <= 1'b1;
        repeat (3) @(posedge clk);
        HOST.latch(8'h03);
        wr(8'hFF, 16'h0050);
        HOST.latch(8'h03);
        rd(8'hFF, 16'hFFFF, 16'h0050, "mux offset");
        @(posedge clk) im <= 1'b0;
        repeat (3) @(posedge clk);
        rd(8'h03, 16'hFFFF, 16'h0050, "plain offset");
        wr(8'h03, 16'h0000);
    endtask
    task automatic t_tx();
        wr(8'h00, 16'h0001);
        wr(8'h94, 16'h4009);
        wr(8'h00, 16'h0000);
        wr(8'h89, 16'h285A);
        tx_get(7'h05);
        check("drive standby", 16'h0000, 16'(w.drive[0]));
        check("proc byte", 16'h00A5, 16'(w.bytes[7:0]));
        @(posedge clk) output_drive_pin <= 1'b1;
        tx_get(7'h05);
        check("drive on", 16'h0001, 16'(w.drive[0]));
        check("upper bytes", 16'h0000, w.bytes[31:16] | 16'(w.bytes[15:8]));
        @(posedge clk) tx_ready <= 1'b0;
        repeat (3 * SLOT_CYCLES) @(posedge clk);
        @(negedge clk);
        check("stall valid", 16'h0001, 16'(tx_valid));
        check("stall word", 16'h0006, 16'(tx_word.chan));
        @(posedge clk) tx_ready <= 1'b1;
        tx_get(7'h07);
        check("drive off", 16'h0000, 16'(w.drive));
        tx_get(7'h14);
        check("loopback", 16'h005A, 16'(w.bytes[15:8]));
    endtask
    task automatic summarize();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        failures = 0;
        comparisons = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_block();
        t_eval();
        t_dmem();
        t_mux();
        t_tx();
        summarize();
    end
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule // test_tsw_switch
`default_nettype wire
